// ---- src/mccc_pkg.sv ----
// Package for the mux and processor clock configuration bank.
// Assumes one clock (the compute-engine clock) and a synchronous active-high reset.
`default_nettype none
package mccc_pkg;
	localparam logic [15:0] MCCC_ADDR_MUX_SEQ = 16'h2002;
	localparam logic [15:0] MCCC_ADDR_CPU_CLK = 16'h2004;
	localparam logic [15:0] MCCC_ADDR_MUX_CTL = 16'h2005;
	localparam int MCCC_STATE_CNT_LSB = 6;
	localparam int MCCC_DIV_LSB       = 0;
	localparam int MCCC_SYNC_EN_BIT   = 0;
	localparam int MCCC_ALT_BIT       = 2;
	localparam logic [1:0] MCCC_STATE_CNT_RST = 2'h0;
	localparam logic [2:0] MCCC_DIV_RST       = 3'h0;
	localparam logic [7:0] MCCC_REG_RST       = 8'h00;
	localparam logic [2:0] MCCC_STATES_6 = 3'h6;
	localparam logic [2:0] MCCC_STATES_4 = 3'h4;
	localparam logic [2:0] MCCC_STATES_3 = 3'h3;
	localparam logic [2:0] MCCC_STATES_2 = 3'h2;

	typedef struct packed {
		logic [1:0] state_count;
		logic       alt_select;
		logic       sync_enable;
		logic [2:0] divider;
	} mccc_cfg_type;
endpackage : mccc_pkg
`default_nettype wire

// ---- src/mccc_top.sv ----
// Configuration bank for multiplexer sequencing and processor clock division.
// Assumes a single-cycle read/write strobe port; read data appears one cycle after the read strobe.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
module mccc_top
	import mccc_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	input  wire logic        SEGMENT_DRIVE,
	input  wire logic        OUTPUT_A_IN,
	output logic      [7:0]  RDATA,
	output logic      [2:0]  MUX_STATES,
	output logic             ALT_INPUT_SELECT,
	output logic             LCD_SEGMENT_PIN_SEVEN,
	output logic             CPU_CLK_EN,
	output logic      [2:0]  CPU_DIV_ACTIVE
);
	function automatic logic [2:0] mccc_states(input logic [1:0] code);
		case (code)
			2'h0:    mccc_states = MCCC_STATES_6;
			2'h1:    mccc_states = MCCC_STATES_4;
			2'h2:    mccc_states = MCCC_STATES_3;
			default: mccc_states = MCCC_STATES_2;
		endcase
	endfunction : mccc_states

	mccc_cfg_type cfg;
	mccc_cfg_type next_cfg;
	logic [7:0]   next_rdata;
	logic [6:0]   cnt;
	logic [6:0]   next_cnt;
	logic [2:0]   div_act;
	logic [2:0]   next_div_act;
	logic         next_clk_en;
	logic [6:0]   limit;
	logic [2:0]   next_mux_states;
	logic         next_alt_select;
	logic         next_pin_seven;

	always_comb begin
		next_cfg = cfg;
		if (WR) begin
			case (ADDR)
				MCCC_ADDR_MUX_SEQ: next_cfg.state_count = WDATA[MCCC_STATE_CNT_LSB +: 2];
				MCCC_ADDR_CPU_CLK: next_cfg.divider = WDATA[MCCC_DIV_LSB +: 3];
				MCCC_ADDR_MUX_CTL: begin
					next_cfg.alt_select  = WDATA[MCCC_ALT_BIT];
					next_cfg.sync_enable = WDATA[MCCC_SYNC_EN_BIT];
				end
				default: next_cfg = cfg;
			endcase
		end
		next_rdata = MCCC_REG_RST;
		if (RD) begin
			case (ADDR)
				MCCC_ADDR_MUX_SEQ: next_rdata[MCCC_STATE_CNT_LSB +: 2] = cfg.state_count;
				MCCC_ADDR_CPU_CLK: next_rdata[MCCC_DIV_LSB +: 3] = cfg.divider;
				MCCC_ADDR_MUX_CTL: begin
					next_rdata[MCCC_ALT_BIT]     = cfg.alt_select;
					next_rdata[MCCC_SYNC_EN_BIT] = cfg.sync_enable;
				end
				default: next_rdata = MCCC_REG_RST;
			endcase
		end
	end

	// Outputs follow the value being stored, so a write shows on the pins one cycle later
	always_comb begin
		next_mux_states = mccc_states(next_cfg.state_count);
		next_alt_select = next_cfg.alt_select;
		next_pin_seven  = next_cfg.sync_enable ? OUTPUT_A_IN : SEGMENT_DRIVE;
	end

	// The processor clock is modelled as an enable, one pulse every 2**div cycles.
	// A new divider is adopted only at a period boundary, so no short period ever occurs.
	always_comb begin
		limit        = 7'((8'h01 << div_act) - 8'h01);
		next_cnt     = cnt + 7'h01;
		next_div_act = div_act;
		next_clk_en  = 1'b0;
		if (cnt >= limit) begin
			next_cnt     = 7'h00;
			next_clk_en  = 1'b1;
			next_div_act = cfg.divider;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			cfg            <= '{state_count: MCCC_STATE_CNT_RST, alt_select: 1'b0, sync_enable: 1'b0,
			                    divider: MCCC_DIV_RST};
			RDATA          <= MCCC_REG_RST;
			cnt            <= 7'h00;
			div_act        <= MCCC_DIV_RST;
			CPU_CLK_EN     <= 1'b0;
			CPU_DIV_ACTIVE <= MCCC_DIV_RST;
			MUX_STATES     <= MCCC_STATES_6;
			ALT_INPUT_SELECT <= 1'b0;
			LCD_SEGMENT_PIN_SEVEN <= 1'b0;
		end else begin
			cfg            <= next_cfg;
			RDATA          <= next_rdata;
			cnt            <= next_cnt;
			div_act        <= next_div_act;
			CPU_CLK_EN     <= next_clk_en;
			CPU_DIV_ACTIVE <= next_div_act;
			MUX_STATES     <= next_mux_states;
			ALT_INPUT_SELECT <= next_alt_select;
			LCD_SEGMENT_PIN_SEVEN <= next_pin_seven;
		end
	end

	// Alternate input set

	AST_ALT_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_CTL |=> ALT_INPUT_SELECT == $past(WDATA[MCCC_ALT_BIT]))
		else $error("alt select not taken from write");

	AST_ALT_HOLDS: assert property (@(posedge SYS_CLK) disable iff (SRST)
		!(WR && ADDR == MCCC_ADDR_MUX_CTL) |=> $stable(ALT_INPUT_SELECT))
		else $error("alt select moved without a write");

	// Multiplexer state count

	AST_STATES_MAP: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_SEQ && WDATA[7:6] == 2'h0 |=> MUX_STATES == 3'h6)
		else $error("code 00 did not give six states");

	AST_STATES_FOUR: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_SEQ && WDATA[7:6] == 2'h1 |=> MUX_STATES == 3'h4)
		else $error("code 01 did not give four states");

	AST_STATES_THREE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_SEQ && WDATA[7:6] == 2'h2 |=> MUX_STATES == 3'h3)
		else $error("code 10 did not give three states");

	AST_STATES_TWO: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_SEQ && WDATA[7:6] == 2'h3 |=> MUX_STATES == 3'h2)
		else $error("code 11 did not give two states");

	AST_STATES_LEGAL: assert property (@(posedge SYS_CLK) disable iff (SRST)
		MUX_STATES inside {3'h6, 3'h4, 3'h3, 3'h2})
		else $error("state count outside the four legal values");

	AST_STATES_HOLD: assert property (@(posedge SYS_CLK) disable iff (SRST)
		!(WR && ADDR == MCCC_ADDR_MUX_SEQ) |=> $stable(MUX_STATES))
		else $error("state count moved without a write");

	// Segment pin seven

	AST_SYNC_FOLLOWS: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_MUX_CTL |=> cfg.sync_enable == $past(WDATA[MCCC_SYNC_EN_BIT]))
		else $error("sync enable not taken from write");

	AST_PIN_SYNC: assert property (@(posedge SYS_CLK) disable iff (SRST)
		$past(cfg.sync_enable) && cfg.sync_enable |-> LCD_SEGMENT_PIN_SEVEN == $past(OUTPUT_A_IN))
		else $error("pin seven not carrying sync signal");

	AST_PIN_SEGMENT: assert property (@(posedge SYS_CLK) disable iff (SRST)
		!$past(SRST) && !cfg.sync_enable |-> LCD_SEGMENT_PIN_SEVEN == $past(SEGMENT_DRIVE))
		else $error("pin seven not carrying segment drive");

	// Processor clock enable

	AST_DIV_PERIOD: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CPU_CLK_EN && CPU_DIV_ACTIVE == 3'h1 && cfg.divider == 3'h1 |=> !CPU_CLK_EN ##1 CPU_CLK_EN)
		else $error("divide by two period wrong");

	AST_DIV_ONE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CPU_DIV_ACTIVE == 3'h0 && $past(CPU_DIV_ACTIVE) == 3'h0 && $past(CPU_CLK_EN) |-> CPU_CLK_EN)
		else $error("undivided clock enable dropped");

	AST_EN_GAP: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CPU_CLK_EN && CPU_DIV_ACTIVE != 3'h0 |=> !CPU_CLK_EN)
		else $error("divided clock enable too long");

	AST_CNT_RANGE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		cnt <= limit)
		else $error("period counter past its limit");

	// A reset that is only checked while asserted would miss a late clear, so check the cycle after

	AST_RESET_DIV: assert property (@(posedge SYS_CLK)
		$past(SRST) && !SRST |-> cfg.divider == 3'h0 && div_act == 3'h0)
		else $error("divider not zero after reset");

	AST_RESET_OUT: assert property (@(posedge SYS_CLK)
		$past(SRST) && !SRST |-> RDATA == 8'h00 && MUX_STATES == 3'h6 && !ALT_INPUT_SELECT
			&& !CPU_CLK_EN && CPU_DIV_ACTIVE == 3'h0 && !LCD_SEGMENT_PIN_SEVEN)
		else $error("outputs not at reset values");

	// Divider changes

	AST_DIV_WRITE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		WR && ADDR == MCCC_ADDR_CPU_CLK |=> cfg.divider == $past(WDATA[MCCC_DIV_LSB +: 3]))
		else $error("divider not taken from write");

	AST_DIV_SWITCH: assert property (@(posedge SYS_CLK) disable iff (SRST)
		$changed(div_act) |-> $past(cnt >= limit))
		else $error("divider switched mid period");

	AST_DIV_WITH_EN: assert property (@(posedge SYS_CLK) disable iff (SRST)
		$changed(CPU_DIV_ACTIVE) |-> CPU_CLK_EN)
		else $error("active divider moved off a period boundary");

	AST_DIV_MATCH: assert property (@(posedge SYS_CLK) disable iff (SRST)
		CPU_DIV_ACTIVE == div_act)
		else $error("reported divider differs from the one in force");

	// Register reads

	AST_READBACK: assert property (@(posedge SYS_CLK) disable iff (SRST)
		RD && ADDR == MCCC_ADDR_CPU_CLK |=> RDATA == {5'h00, $past(cfg.divider)})
		else $error("divider readback wrong");

	AST_READ_SEQ: assert property (@(posedge SYS_CLK) disable iff (SRST)
		RD && ADDR == MCCC_ADDR_MUX_SEQ |=> RDATA == {$past(cfg.state_count), 6'h00})
		else $error("state count readback wrong");

	AST_READ_CTL: assert property (@(posedge SYS_CLK) disable iff (SRST)
		RD && ADDR == MCCC_ADDR_MUX_CTL |=>
			RDATA == {5'h00, $past(cfg.alt_select), 1'b0, $past(cfg.sync_enable)})
		else $error("control readback wrong");

	AST_READ_IDLE: assert property (@(posedge SYS_CLK) disable iff (SRST)
		!RD |=> RDATA == 8'h00)
		else $error("read data not zero outside a read");

endmodule : mccc_top
`default_nettype wire

// ---- dv/mccc_top_bench.sv ----
// Directed bench for the mux and processor clock configuration bank.
// Assumes the strobe register port and one 125 MHz clock; the bench drives every input.
`default_nettype none
module mccc_top_bench;
	import mccc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 0, srst = 1, wr = 0, rd = 0, segment_drive = 0, output_a_in = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00, rdata;
	logic [2:0]  mux_states, cpu_div_active;
	logic        alt_input_select, lcd_segment_pin_seven, cpu_clk_en;
	int          mismatches = 0, cmp_count = 0, n;
	logic [2:0]  states_tbl [4] = '{MCCC_STATES_6, MCCC_STATES_4, MCCC_STATES_3, MCCC_STATES_2};
	mccc_top u_mccc_top (.SYS_CLK(sys_clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.SEGMENT_DRIVE(segment_drive), .OUTPUT_A_IN(output_a_in), .RDATA(rdata), .MUX_STATES(mux_states),
		.ALT_INPUT_SELECT(alt_input_select), .LCD_SEGMENT_PIN_SEVEN(lcd_segment_pin_seven), .CPU_CLK_EN(cpu_clk_en),
		.CPU_DIV_ACTIVE(cpu_div_active));
	initial forever #4 sys_clk = ~sys_clk;
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task wreg(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk); wr <= 1; addr <= a; wdata <= d;
		@(posedge sys_clk); wr <= 0;
	endtask : wreg
	task rchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk); rd <= 1; addr <= a;
		@(posedge sys_clk); rd <= 0;
		#1 chk("rdata", exp, rdata);
		@(posedge sys_clk);
		#1 chk("rdata_idle", 8'h00, rdata);
	endtask : rchk
	// Pin output is registered, so give it two edges after the inputs move
	task pins(input logic a, input logic s, input logic exp);
		@(posedge sys_clk); output_a_in <= a; segment_drive <= s;
		repeat (2) @(posedge sys_clk);
		#1 chk("pin_seven", {7'h00, exp}, {7'h00, lcd_segment_pin_seven});
	endtask : pins
	task t_reset;
		#1 chk("div", 8'h00, {5'h00, cpu_div_active});
		chk("states", 8'h06, {5'h00, mux_states});
		rchk(MCCC_ADDR_CPU_CLK, 8'h00);
		chk("clk_en", 8'h01, {7'h00, cpu_clk_en});
	endtask : t_reset
	task t_states;
		for (int i = 0; i < 4; i++) begin
			wreg(MCCC_ADDR_MUX_SEQ, 8'(i << 6));
			@(posedge sys_clk);
			#1 chk("states", {5'h00, states_tbl[i]}, {5'h00, mux_states});
			rchk(MCCC_ADDR_MUX_SEQ, 8'(i << 6));
		end
	endtask : t_states
	task t_mux_ctl;
		wreg(MCCC_ADDR_MUX_CTL, 8'h05);
		pins(1, 0, 1);
		pins(0, 1, 0);
		chk("alt", 8'h01, {7'h00, alt_input_select});
		rchk(MCCC_ADDR_MUX_CTL, 8'h05);
		wreg(MCCC_ADDR_MUX_CTL, 8'h00);
		pins(1, 0, 0);
		pins(0, 1, 1);
		chk("alt", 8'h00, {7'h00, alt_input_select});
	endtask : t_mux_ctl
	task t_divider;
		// Ends 7 then 0 so a slow divider is rewritten to full rate in mid-run
		for (int k = 0; k < 9; k++) begin
			wreg(MCCC_ADDR_CPU_CLK, 8'(k % 8));
			for (n = 0; n < 300 && cpu_div_active !== 3'(k % 8); n++) @(posedge sys_clk) #1;
			chk("div", 8'(k % 8), {5'h00, cpu_div_active});
			for (n = 0; n < 300 && cpu_clk_en !== 1'b1; n++) @(posedge sys_clk) #1;
			n = 0;
			do begin @(posedge sys_clk) #1; n++; end while (cpu_clk_en !== 1'b1 && n < 300);
			chk("period", 8'(1 << (k % 8)), 8'(n));
			rchk(MCCC_ADDR_CPU_CLK, 8'(k % 8));
		end
	endtask : t_divider
	task t_unmapped;
		wreg(16'h2003, 8'hff);
		rchk(16'h2003, 8'h00);
		rchk(MCCC_ADDR_MUX_CTL, 8'h00);
	endtask : t_unmapped
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	initial begin
		#400000;
		mismatches++;
		test_done();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		srst <= 0;
		@(posedge sys_clk);
		t_reset();
		t_states();
		t_mux_ctl();
		t_divider();
		t_unmapped();
		test_done();
	end
endmodule : mccc_top_bench
`default_nettype wire
